// File: design/nvm_pkg.sv
/*
 * Constants shared by the word programming port: register offsets, field
 * positions, reset values, the pulse time and the sequencer state encoding.
 * Assumes a 200 MHz core clock.
 */
package nvm_pkg;

    // ==================================================================
    // Geometry
    localparam int unsigned WORD_COUNT  = 24;
    localparam int unsigned WORD_WIDTH  = 16;
    localparam int unsigned INDEX_WIDTH = 5;
    localparam int unsigned ADDR_WIDTH  = 8;

    // ==================================================================
    // Register offsets
    localparam logic [7:0] CONTROL_OFFSET = 8'hA1;
    localparam logic [7:0] INDEX_OFFSET   = 8'hA2;
    localparam logic [7:0] VALUE_OFFSET   = 8'hA3;

    // ==================================================================
    // Control fields
    localparam int unsigned HV_BIT        = 0;
    localparam int unsigned WIPE_BIT      = 1;
    localparam int unsigned WRITE_BIT     = 2;
    localparam int unsigned READ_BIT      = 3;
    localparam int unsigned CONTROL_USED  = 4;

    // ==================================================================
    // Reset values
    localparam logic [3:0]  CONTROL_RESET = 4'h0;
    localparam logic [4:0]  INDEX_RESET   = 5'h00;
    localparam logic [15:0] VALUE_RESET   = 16'h0000;
    localparam logic [15:0] ERASED_WORD   = 16'h0000;

    // ==================================================================
    // Timing
    localparam int unsigned PROG_TIME_US  = 10000;
    localparam int unsigned CLK_FREQ_MHZ  = 200;
    localparam int unsigned PROG_CYCLES   = PROG_TIME_US * CLK_FREQ_MHZ;

    // ==================================================================
    // Sequencer states, Gray coded along idle, pulse, commit.
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_PULSE  = 2'b01,
        ST_COMMIT = 2'b11
    } prog_state_e;

endpackage : nvm_pkg

// File: design/nvm_word_store.sv
/*
 * Flip-flop model of the nonvolatile word array with one commit port.
 * Assumes the caller presents commit for one cycle with a stable index.
 */
`timescale 1ns/1ps

module nvm_word_store #(
    parameter int unsigned WORDS = nvm_pkg::WORD_COUNT,
    parameter int unsigned WIDTH = nvm_pkg::WORD_WIDTH,
    parameter int unsigned IW    = nvm_pkg::INDEX_WIDTH
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             commit,
    input  wire logic             wipe,
    input  wire logic [IW-1:0]    index,
    input  wire logic [WIDTH-1:0] value,
    output logic      [WIDTH-1:0] words [WORDS]
);

    // ==================================================================
    // Storage
    // Programming only sets bits, so a word must be wiped before it can
    // take a value with fewer ones.
    for (genvar i = 0; i < WORDS; i++) begin : g_word
        logic [WIDTH-1:0] next_word;

        always_comb begin
            next_word = words[i];
            if (commit && index == IW'(i)) begin
                next_word = wipe ? nvm_pkg::ERASED_WORD : (words[i] | value); // RULE1
            end
        end

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                words[i] <= nvm_pkg::ERASED_WORD;
            end else begin
                words[i] <= next_word;
            end
        end
    end

endmodule : nvm_word_store

// File: design/nvm_word_programming_port.sv
/*
 * Word programming port: control, index and value registers, the
 * high-voltage pulse sequencer and read-back of stored words.
 * Assumes a decoded register port from the serial bus front end, one
 * access per strobe, with inputs synchronous to core_clk.
 */
// What this block does
// RULE1: Holds twenty-four sixteen-bit nonvolatile words, programmed through control, index, value registers.
// RULE2: Control bit 0 enables high voltage, bit 1 erase, bit 2 write, bit 3 read; code stores bit 3 but never acts on it.
// RULE3: Host keeps control bits 15:4 and index bits 15:5 zero while programming.
// RULE4: Index register takes the target word index in bits 4:0.
// RULE5: Host never erases or writes word 0 or word 19.
// RULE6: Value register holds the full sixteen-bit word to program.
// RULE7: Host erases a word before writing it.
// RULE8: Each erase or write occupies about 10 ms.
// RULE9: Host programs one word per index, value, control sequence.
// RULE10: Erase sequence: index, value zero, control 3, wait 15 ms.
// RULE11: Write sequence: index, new value, control 5, wait 15 ms.
// RULE12: Reading register number equal to a word index returns that stored word.
// RULE13: Host returns control to zero after each wait before the next word.
`timescale 1ns/1ps

module nvm_word_programming_port #(
    parameter int unsigned PROG_CYCLES = nvm_pkg::PROG_CYCLES
) (
    input  wire logic                            core_clk,
    input  wire logic                            resetn,
    input  wire logic                            reg_wr_en,
    input  wire logic                            reg_rd_en,
    input  wire logic [nvm_pkg::ADDR_WIDTH-1:0]  reg_addr,
    input  wire logic [nvm_pkg::WORD_WIDTH-1:0]  reg_wdata,
    output logic      [nvm_pkg::WORD_WIDTH-1:0]  rd_data,
    output logic                                 rd_valid,
    output logic                                 hv_enable,
    output logic                                 prog_busy
);

    // ==================================================================
    // Reset release
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ==================================================================
    // Registers
    logic [nvm_pkg::CONTROL_USED-1:0] control;
    logic [nvm_pkg::INDEX_WIDTH-1:0]  target_word_index;
    logic [nvm_pkg::WORD_WIDTH-1:0]   new_word_value;
    logic [nvm_pkg::CONTROL_USED-1:0] next_control;
    logic [nvm_pkg::INDEX_WIDTH-1:0]  next_target_word_index;
    logic [nvm_pkg::WORD_WIDTH-1:0]   next_new_word_value;
    logic                             wr_control;

    assign wr_control = reg_wr_en && reg_addr == nvm_pkg::CONTROL_OFFSET;

    // Upper bits are not stored, so they always read as zero.
    always_comb begin
        next_control           = control;
        next_target_word_index = target_word_index;
        next_new_word_value    = new_word_value;
        if (wr_control) begin
            next_control = reg_wdata[nvm_pkg::CONTROL_USED-1:0]; // RULE2
        end
        if (reg_wr_en && reg_addr == nvm_pkg::INDEX_OFFSET) begin
            next_target_word_index = reg_wdata[nvm_pkg::INDEX_WIDTH-1:0]; // RULE4
        end
        if (reg_wr_en && reg_addr == nvm_pkg::VALUE_OFFSET) begin
            next_new_word_value = reg_wdata; // RULE6
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            control           <= nvm_pkg::CONTROL_RESET;
            target_word_index <= nvm_pkg::INDEX_RESET;
            new_word_value    <= nvm_pkg::VALUE_RESET;
        end else begin
            control           <= next_control;
            target_word_index <= next_target_word_index;
            new_word_value    <= next_new_word_value;
        end
    end

    // ==================================================================
    // Pulse sequencer
    // Index and value are latched at the start, so the host may stage the
    // next word's registers during the pulse without disturbing it.
    nvm_pkg::prog_state_e            state;
    nvm_pkg::prog_state_e            next_state;
    logic [31:0]                     pulse_count;
    logic [31:0]                     next_pulse_count;
    logic                            op_wipe;
    logic                            next_op_wipe;
    logic [nvm_pkg::INDEX_WIDTH-1:0] op_index;
    logic [nvm_pkg::INDEX_WIDTH-1:0] next_op_index;
    logic [nvm_pkg::WORD_WIDTH-1:0]  op_value;
    logic [nvm_pkg::WORD_WIDTH-1:0]  next_op_value;
    logic                            start;
    logic                            next_prog_busy;

    assign start = state == nvm_pkg::ST_IDLE && wr_control && reg_wdata[nvm_pkg::HV_BIT]
                   && (reg_wdata[nvm_pkg::WIPE_BIT] ^ reg_wdata[nvm_pkg::WRITE_BIT]); // RULE2

    always_comb begin
        next_state       = state;
        next_pulse_count = pulse_count;
        next_op_wipe     = op_wipe;
        next_op_index    = op_index;
        next_op_value    = op_value;
        unique case (state)
            nvm_pkg::ST_IDLE: begin
                if (start) begin
                    next_state       = nvm_pkg::ST_PULSE;
                    next_pulse_count = 32'(PROG_CYCLES); // RULE8
                    next_op_wipe     = reg_wdata[nvm_pkg::WIPE_BIT];
                    next_op_index    = target_word_index;
                    next_op_value    = new_word_value;
                end
            end
            nvm_pkg::ST_PULSE: begin
                next_pulse_count = pulse_count - 32'h1;
                if (pulse_count == 32'h1) begin
                    next_state = nvm_pkg::ST_COMMIT; // RULE8
                end
            end
            nvm_pkg::ST_COMMIT: begin
                next_state = nvm_pkg::ST_IDLE;
            end
            default: begin
                next_state = nvm_pkg::ST_IDLE;
            end
        endcase
        next_prog_busy = next_state != nvm_pkg::ST_IDLE;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= nvm_pkg::ST_IDLE;
            pulse_count <= 32'h0;
            op_wipe     <= 1'b0;
            op_index    <= nvm_pkg::INDEX_RESET;
            op_value    <= nvm_pkg::VALUE_RESET;
            prog_busy   <= 1'b0;
        end else begin
            state       <= next_state;
            pulse_count <= next_pulse_count;
            op_wipe     <= next_op_wipe;
            op_index    <= next_op_index;
            op_value    <= next_op_value;
            prog_busy   <= next_prog_busy;
        end
    end

    assign hv_enable = control[nvm_pkg::HV_BIT];

    // ==================================================================
    // Word array
    logic [nvm_pkg::WORD_WIDTH-1:0] words [nvm_pkg::WORD_COUNT];

    nvm_word_store #(
        .WORDS (nvm_pkg::WORD_COUNT),
        .WIDTH (nvm_pkg::WORD_WIDTH),
        .IW    (nvm_pkg::INDEX_WIDTH)
    ) u_store (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .commit   (state == nvm_pkg::ST_COMMIT),
        .wipe     (op_wipe),
        .index    (op_index),
        .value    (op_value),
        .words    (words)
    );

    // ==================================================================
    // Read path
    logic [nvm_pkg::WORD_WIDTH-1:0] next_rd_data;

    always_comb begin
        next_rd_data = rd_data;
        if (reg_rd_en) begin
            next_rd_data = '0;
            if (reg_addr < nvm_pkg::ADDR_WIDTH'(nvm_pkg::WORD_COUNT)) begin
                next_rd_data = words[reg_addr[nvm_pkg::INDEX_WIDTH-1:0]]; // RULE12
            end else if (reg_addr == nvm_pkg::CONTROL_OFFSET) begin
                next_rd_data[nvm_pkg::CONTROL_USED-1:0] = control;
            end else if (reg_addr == nvm_pkg::INDEX_OFFSET) begin
                next_rd_data[nvm_pkg::INDEX_WIDTH-1:0] = target_word_index;
            end else if (reg_addr == nvm_pkg::VALUE_OFFSET) begin
                next_rd_data = new_word_value;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_data  <= next_rd_data;
            rd_valid <= reg_rd_en;
        end
    end

    // ==================================================================
    // Checks
    logic [31:0] busy_len;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_len <= 32'h0;
        end else begin
            busy_len <= prog_busy ? busy_len + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_start_sets_busy: assert property (start |=> prog_busy) // RULE2
        else $error("Programming pulse did not start.");
    a_no_hv_no_start: assert property (wr_control && !reg_wdata[nvm_pkg::HV_BIT] && !prog_busy
        |=> !prog_busy) // RULE2
        else $error("Pulse started without high voltage.");
    a_pulse_length: assert property ($fell(prog_busy) |-> busy_len == 32'(PROG_CYCLES) + 32'h1) // RULE8
        else $error("Pulse length wrong.");
    a_commit_write: assert property (state == nvm_pkg::ST_COMMIT && !op_wipe
        && op_index < nvm_pkg::INDEX_WIDTH'(nvm_pkg::WORD_COUNT)
        |=> words[op_index] == ($past(words[op_index]) | $past(op_value))) // RULE6
        else $error("Write did not store the value.");
    a_commit_wipe: assert property (state == nvm_pkg::ST_COMMIT && op_wipe
        && op_index < nvm_pkg::INDEX_WIDTH'(nvm_pkg::WORD_COUNT)
        |=> words[op_index] == nvm_pkg::ERASED_WORD) // RULE1
        else $error("Erase did not clear the word.");
    a_read_word: assert property (reg_rd_en && reg_addr < nvm_pkg::ADDR_WIDTH'(nvm_pkg::WORD_COUNT)
        |=> rd_valid && rd_data == $past(words[reg_addr[nvm_pkg::INDEX_WIDTH-1:0]])) // RULE12
        else $error("Word read-back wrong.");
    a_index_field: assert property (reg_wr_en && reg_addr == nvm_pkg::INDEX_OFFSET
        |=> target_word_index == $past(reg_wdata[nvm_pkg::INDEX_WIDTH-1:0])) // RULE4
        else $error("Index register not updated.");
    a_control_upper: assert property (reg_rd_en && reg_addr == nvm_pkg::CONTROL_OFFSET
        |=> rd_data[nvm_pkg::WORD_WIDTH-1:nvm_pkg::CONTROL_USED] == '0) // RULE2
        else $error("Control upper bits not zero.");

    c_erase_op: cover property (state == nvm_pkg::ST_COMMIT && op_wipe);
    c_write_op: cover property (state == nvm_pkg::ST_COMMIT && !op_wipe);
    c_word_read: cover property (reg_rd_en && reg_addr < nvm_pkg::ADDR_WIDTH'(nvm_pkg::WORD_COUNT));

endmodule : nvm_word_programming_port

// File: tb/bus_host_model.sv
/*
 * Behavioural model of the serial bus host controller seen through the
 * decoded register port: one-cycle write and read strobes.
 * Assumes the caller waits out each programming pulse itself.
 */
`timescale 1ns/1ps

module bus_host_model (
    input  wire logic                           core_clk,
    output logic                                reg_wr_en,
    output logic                                reg_rd_en,
    output logic [nvm_pkg::ADDR_WIDTH-1:0]      reg_addr,
    output logic [nvm_pkg::WORD_WIDTH-1:0]      reg_wdata,
    input  wire logic [nvm_pkg::WORD_WIDTH-1:0] rd_data,
    input  wire logic                           rd_valid
);
    // ==================================================================
    // Bus cycles
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
    end

    // Idle lines show the inverse so a stale value can never look valid.
    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        reg_addr  <= ~addr;
        reg_wdata <= ~data;
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [15:0] data, output logic valid);
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr  <= addr;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~addr;
        #1;
        data  = rd_data;
        valid = rd_valid;
    endtask : rd

endmodule : bus_host_model

// File: tb/tb.sv
/*
 * Self-checking bench for the word programming port with a short pulse.
 * Assumes the host model drives every register access.
 */
`timescale 1ns/1ps

module tb;
    // ==================================================================
    // Signals
    localparam int unsigned PC        = 20;
    localparam logic [15:0] CTL_ERASE = 16'h0003;
    localparam logic [15:0] CTL_WRITE = 16'h0005;
    logic        core_clk;
    logic        resetn;
    logic        reg_wr_en;
    logic        reg_rd_en;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        hv_enable;
    logic        prog_busy;
    logic [15:0] model [24];
    logic [15:0] codes [5] = '{16'h0007, 16'h0002, 16'h0004, 16'h0001, 16'h0006};
    logic [31:0] r;
    logic [4:0]  idx;
    int          n_errors;
    int          n_compared;
    int          busy_cycles;
    int          cycles;

    nvm_word_programming_port #(.PROG_CYCLES(PC)) dut_u (
        .core_clk(core_clk), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
        .hv_enable(hv_enable), .prog_busy(prog_busy));
    bus_host_model host_u (
        .core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

    always #2.5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (prog_busy === 1'b1) busy_cycles++;
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    // ==================================================================
    // Checks and expectations
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_flag

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] got;
        logic        vld;
        host_u.rd(a, got, vld);
        chk_flag(vld, 1'b1);
        chk_val(got, exp);
    endtask : rd_chk

    // Writes only set bits, which is why an erase must come first.
    function automatic logic [15:0] next_word(input logic [15:0] old, input logic [15:0] val,
                                              input logic [15:0] ctl);
        return ctl[1] ? nvm_pkg::ERASED_WORD : (old | val);
    endfunction : next_word

    task automatic run_op(input logic [4:0] i, input logic [15:0] val, input logic [15:0] ctl,
                          input bit again);
        int k;
        host_u.wr(nvm_pkg::INDEX_OFFSET, {11'h000, i});
        host_u.wr(nvm_pkg::VALUE_OFFSET, val);
        busy_cycles = 0;
        host_u.wr(nvm_pkg::CONTROL_OFFSET, ctl);
        #1;
        chk_flag(hv_enable, 1'b1);
        chk_flag(prog_busy, 1'b1);
        if (again) host_u.wr(nvm_pkg::CONTROL_OFFSET, ctl);
        k = 0;
        while (prog_busy !== 1'b0 && k < 200) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk_val(16'(busy_cycles), 16'(PC + 1));
        host_u.wr(nvm_pkg::CONTROL_OFFSET, 16'h0000);
        if (i < 24) begin
            model[i] = next_word(model[i], val, ctl);
            rd_chk({3'h0, i}, model[i]);
        end
    endtask : run_op

    task automatic stop_test();
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // ==================================================================
    // Main sequence
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        n_errors = 0;
        n_compared = 0;
        busy_cycles = 0;
        cycles = 0;
        r = $urandom(2707);
        foreach (model[i]) model[i] = nvm_pkg::ERASED_WORD;
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk_flag(hv_enable, 1'b0);
        chk_flag(prog_busy, 1'b0);
        rd_chk(nvm_pkg::CONTROL_OFFSET, 16'h0000);
        rd_chk(nvm_pkg::INDEX_OFFSET, 16'h0000);
        rd_chk(nvm_pkg::VALUE_OFFSET, 16'h0000);
        r = $urandom;
        host_u.wr(nvm_pkg::INDEX_OFFSET, r[15:0]);
        rd_chk(nvm_pkg::INDEX_OFFSET, {11'h000, r[4:0]});
        host_u.wr(nvm_pkg::VALUE_OFFSET, r[31:16]);
        host_u.wr(8'hA4, ~r[31:16]);
        rd_chk(nvm_pkg::VALUE_OFFSET, r[31:16]);
        rd_chk(8'hA4, 16'h0000);
        rd_chk(8'h18, 16'h0000);
        host_u.wr(nvm_pkg::CONTROL_OFFSET, 16'hFFF8);
        rd_chk(nvm_pkg::CONTROL_OFFSET, 16'h0008);
        foreach (codes[j]) begin
            host_u.wr(nvm_pkg::CONTROL_OFFSET, codes[j]);
            repeat (3) @(posedge core_clk);
            #1;
            chk_flag(prog_busy, 1'b0);
            chk_flag(hv_enable, codes[j][0]);
            rd_chk(nvm_pkg::CONTROL_OFFSET, codes[j]);
        end
        host_u.wr(nvm_pkg::CONTROL_OFFSET, 16'h0000);
        run_op(5'd23, 16'h0000, CTL_ERASE, 1'b0);
        run_op(5'd23, 16'hFFFF, CTL_WRITE, 1'b0);
        repeat (3) begin
            idx = 5'(1 + $urandom % 18);
            r = $urandom;
            run_op(idx, 16'h0000, CTL_ERASE, 1'b0);
            run_op(idx, r[15:0], CTL_WRITE, 1'b0);
        end
        run_op(5'd20, 16'h0000, CTL_ERASE, 1'b1);
        run_op(5'd20, 16'h0105, CTL_WRITE, 1'b1);
        run_op(5'd25, 16'h1234, CTL_WRITE, 1'b0);
        for (int i = 0; i < 24; i++) begin
            rd_chk(8'(i), model[i]);
        end
        stop_test();
    end

endmodule : tb
